//--- rtl/tpc_timers.sv
// Two independent 32-bit peripheral timers: pulse output, width capture,
// external event counter. Assumes timer inputs arrive asynchronously
// and the register port is driven from the mclk domain.
`timescale 1ns/1ns
module tpc_timers (
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Register port
    input wire tpc_pkg::tpc_req_t req,
    output logic [31:0] rdata,
    output logic rvalid,
    // Timer pins
    input wire logic [tpc_pkg::NTMR-1:0] tmr_in,
    output logic [tpc_pkg::NTMR-1:0] tmr_out,
    output logic [tpc_pkg::NTMR-1:0] pben_n,
    // Interrupt requests
    output logic [tpc_pkg::NTMR-1:0] irq_req
);

    // Half-rate tick: every pulse and capture count step spans two clocks
    logic tick_r;

    always_ff @(posedge mclk)
    begin
        if (srst)
            tick_r <= 1'b0;
        else
            tick_r <= ~tick_r;
    end

    logic stat_wr;
    assign stat_wr = req.wr && (req.addr == tpc_pkg::OFS_STAT);

    // Per-timer views for the read mux
    tpc_pkg::tpc_ctl_t ctl_v [tpc_pkg::NTMR];
    logic [31:0] cnt_v [tpc_pkg::NTMR];
    logic [31:0] prd_v [tpc_pkg::NTMR];
    logic [31:0] wid_v [tpc_pkg::NTMR];
    logic [tpc_pkg::NTMR-1:0] en_v;
    logic [tpc_pkg::NTMR-1:0] irq_v;
    logic [tpc_pkg::NTMR-1:0] ovf_v;

    genvar gi;
    generate
        for (gi = 0; gi < tpc_pkg::NTMR; gi++)
        begin : g_tmr
            localparam logic [7:0] BASE =
                8'(tpc_pkg::OFS_TMR0 + gi * tpc_pkg::OFS_TSTRIDE);

            tpc_pkg::tpc_ctl_t ctl_r;
            logic en_r;
            logic irq_r;
            logic ovf_r;
            logic ev_irq_r;
            logic ev_ovf_r;
            logic [31:0] cnt_r;
            logic [31:0] prd_r;
            logic [31:0] wid_r;
            logic [31:0] prdb_r;
            logic [31:0] widb_r;
            logic act_r;
            logic armed_r;
            logic [2:0] sync_r;
            logic wr_ctl;
            logic wr_prd;
            logic wr_wid;
            logic en_set;
            logic dis_set;
            logic pwm_ok;
            logic rise;
            logic fall;
            logic lead;
            logic trail;
            logic [30:0] p31;
            logic [30:0] w31;

            assign wr_ctl = req.wr && (req.addr == BASE + 8'(tpc_pkg::OFS_CTL));
            assign wr_prd = req.wr && (req.addr == BASE + 8'(tpc_pkg::OFS_PRD));
            assign wr_wid = req.wr && (req.addr == BASE + 8'(tpc_pkg::OFS_WID));
            assign en_set = stat_wr && req.wdata[tpc_pkg::ST_EN + gi];
            assign dis_set = stat_wr && req.wdata[tpc_pkg::ST_DIS + gi];

            // Only bits 30..0 take part in timing
            assign p31 = prdb_r[30:0];
            assign w31 = widb_r[30:0];
            // Period must exceed width and width be nonzero
            assign pwm_ok = (w31 != 31'h0000_0000) && (p31 > w31);

            // Three-stage input sampler; stage 1 feeds stage 2 only
            always_ff @(posedge mclk)
            begin
                if (srst)
                    sync_r <= 3'h0;
                else
                    sync_r <= {sync_r[1:0], tmr_in[gi]};
            end

            // Change counts once stages 2 and 3 disagree
            assign rise = sync_r[1] && !sync_r[2];
            assign fall = !sync_r[1] && sync_r[2];
            assign lead = ctl_r.pulse ? rise : fall;
            assign trail = ctl_r.pulse ? fall : rise;

            // Control register
            always_ff @(posedge mclk)
            begin
                if (srst)
                    ctl_r <= '0;
                else if (wr_ctl)
                    ctl_r <= tpc_pkg::tpc_ctl_t'(req.wdata[4:0]);
            end

            // Period and width buffers; capture mode loads them itself
            always_ff @(posedge mclk)
            begin
                if (srst)
                begin
                    prdb_r <= tpc_pkg::RST_WORD;
                    widb_r <= tpc_pkg::RST_WORD;
                end
                else if (ctl_r.mode == tpc_pkg::TPC_MODE_CAP)
                begin
                    if (en_r && armed_r && lead)
                        prdb_r <= cnt_r;
                    if (en_r && armed_r && trail)
                        widb_r <= cnt_r;
                end
                else
                begin
                    if (wr_prd)
                        prdb_r <= req.wdata;
                    if (wr_wid && ctl_r.mode != tpc_pkg::TPC_MODE_EXT)
                        widb_r <= req.wdata;
                end
            end

            // Counter, run state and waveform phase
            always_ff @(posedge mclk)
            begin
                if (srst)
                begin
                    en_r <= 1'b0;
                    cnt_r <= tpc_pkg::RST_WORD;
                    prd_r <= tpc_pkg::RST_WORD;
                    wid_r <= tpc_pkg::RST_WORD;
                    act_r <= 1'b0;
                    armed_r <= 1'b0;
                    ev_irq_r <= 1'b0;
                    ev_ovf_r <= 1'b0;
                end
                else
                begin
                    ev_irq_r <= 1'b0;
                    ev_ovf_r <= 1'b0;
                    if (!en_r)
                    begin
                        // Stopped: buffers pass straight through
                        prd_r <= prdb_r;
                        wid_r <= widb_r;
                        if (en_set && !dis_set)
                        begin
                            unique case (ctl_r.mode)
                                tpc_pkg::TPC_MODE_PWM:
                                    if (pwm_ok)
                                    begin
                                        en_r <= 1'b1;
                                        act_r <= 1'b1;
                                        cnt_r <= tpc_pkg::CNT_ALL1 -
                                            {1'b0, w31};
                                    end
                                    else
                                    begin
                                        ev_irq_r <= 1'b1;
                                        ev_ovf_r <= 1'b1;
                                    end
                                tpc_pkg::TPC_MODE_CAP:
                                begin
                                    en_r <= 1'b1;
                                    armed_r <= 1'b0;
                                    cnt_r <= tpc_pkg::CNT_ONE;
                                end
                                tpc_pkg::TPC_MODE_EXT:
                                begin
                                    en_r <= 1'b1;
                                    armed_r <= 1'b0;
                                    cnt_r <= tpc_pkg::CNT_ALL1 -
                                        {1'b0, p31};
                                end
                                tpc_pkg::TPC_MODE_OFF:
                                    en_r <= 1'b0;
                            endcase
                        end
                    end
                    else if (dis_set)
                        en_r <= 1'b0;
                    else
                    begin
                        unique case (ctl_r.mode)
                            tpc_pkg::TPC_MODE_PWM:
                                if (tick_r)
                                begin
                                    if (cnt_r < tpc_pkg::CNT_ALL1_M1)
                                        cnt_r <= cnt_r + 32'h0000_0001;
                                    else if (act_r)
                                    begin
                                        // End of width
                                        act_r <= 1'b0;
                                        cnt_r <= tpc_pkg::CNT_ALL1 -
                                            ({1'b0, prd_r[30:0]} -
                                             {1'b0, wid_r[30:0]});
                                        if (!ctl_r.per_cont)
                                        begin
                                            ev_irq_r <= 1'b1;
                                            en_r <= 1'b0;
                                        end
                                    end
                                    else
                                    begin
                                        // End of period: take buffers
                                        act_r <= 1'b1;
                                        prd_r <= prdb_r;
                                        wid_r <= widb_r;
                                        cnt_r <= tpc_pkg::CNT_ALL1 -
                                            {1'b0, w31};
                                        ev_irq_r <= 1'b1;
                                    end
                                end
                            tpc_pkg::TPC_MODE_CAP:
                            begin
                                if (lead)
                                begin
                                    armed_r <= 1'b1;
                                    cnt_r <= tpc_pkg::CNT_ONE;
                                    if (armed_r && ctl_r.per_cont)
                                        ev_irq_r <= 1'b1;
                                end
                                else if (armed_r && trail && !ctl_r.per_cont)
                                    ev_irq_r <= 1'b1;
                                else if (armed_r && tick_r)
                                begin
                                    if (cnt_r == tpc_pkg::CNT_ALL1)
                                    begin
                                        en_r <= 1'b0;
                                        ev_ovf_r <= 1'b1;
                                        ev_irq_r <= 1'b1;
                                    end
                                    else
                                        cnt_r <= cnt_r + 32'h0000_0001;
                                end
                                prd_r <= prdb_r;
                                wid_r <= widb_r;
                            end
                            tpc_pkg::TPC_MODE_EXT:
                                if (lead)
                                begin
                                    armed_r <= 1'b1;
                                    if (!armed_r ||
                                        cnt_r == tpc_pkg::CNT_ALL1_M1)
                                    begin
                                        prd_r <= prdb_r;
                                        cnt_r <= tpc_pkg::CNT_ALL1 -
                                            {1'b0, p31};
                                    end
                                    else
                                    begin
                                        cnt_r <= cnt_r + 32'h0000_0001;
                                        if (cnt_r + 32'h0000_0001 ==
                                            tpc_pkg::CNT_ALL1_M1)
                                            ev_irq_r <= 1'b1;
                                    end
                                end
                            tpc_pkg::TPC_MODE_OFF:
                                en_r <= 1'b0;
                        endcase
                    end
                end
            end

            // Sticky flags: hardware set beats a write-one clear
            always_ff @(posedge mclk)
            begin
                if (srst)
                begin
                    irq_r <= 1'b0;
                    ovf_r <= 1'b0;
                end
                else
                begin
                    irq_r <= ev_irq_r || (irq_r &&
                        !(stat_wr && req.wdata[tpc_pkg::ST_IRQ + gi]));
                    ovf_r <= ev_ovf_r || (ovf_r &&
                        !(stat_wr && req.wdata[tpc_pkg::ST_OVF + gi]));
                end
            end

            // Pin drive: registered so the level never glitches
            always_ff @(posedge mclk)
            begin
                if (srst)
                begin
                    tmr_out[gi] <= 1'b0;
                    pben_n[gi] <= 1'b1;
                end
                else
                begin
                    pben_n[gi] <=
                        (ctl_r.mode != tpc_pkg::TPC_MODE_PWM);
                    // Idle state is the deasserted level
                    tmr_out[gi] <= (en_r && act_r) ? ctl_r.pulse
                                                   : !ctl_r.pulse;
                end
            end

            assign irq_req[gi] = irq_r && ctl_r.irq_on;

            assign ctl_v[gi] = ctl_r;
            assign cnt_v[gi] = cnt_r;
            assign prd_v[gi] = prd_r;
            assign wid_v[gi] =
                (ctl_r.mode == tpc_pkg::TPC_MODE_EXT) ? 32'h0000_0000 : wid_r;
            assign en_v[gi] = en_r;
            assign irq_v[gi] = irq_r;
            assign ovf_v[gi] = ovf_r;
        end
    endgenerate

    // Read mux
    logic [31:0] rd_nxt;

    always_comb
    begin
        rd_nxt = 32'h0000_0000;
        if (req.addr == tpc_pkg::OFS_STAT)
        begin
            rd_nxt[tpc_pkg::ST_IRQ +: tpc_pkg::NTMR] = irq_v;
            rd_nxt[tpc_pkg::ST_OVF +: tpc_pkg::NTMR] = ovf_v;
            rd_nxt[tpc_pkg::ST_EN +: tpc_pkg::NTMR] = en_v;
        end
        for (int k = 0; k < tpc_pkg::NTMR; k++)
        begin
            if (req.addr[7:4] == 4'(k + 1))
            begin
                unique case (req.addr[3:0])
                    tpc_pkg::OFS_CTL: rd_nxt = {27'h0, ctl_v[k]};
                    tpc_pkg::OFS_CNT: rd_nxt = cnt_v[k];
                    tpc_pkg::OFS_PRD: rd_nxt = prd_v[k];
                    tpc_pkg::OFS_WID: rd_nxt = wid_v[k];
                    default: rd_nxt = 32'h0000_0000;
                endcase
            end
        end
    end

    // Read data one clock after the strobe
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            rdata <= 32'h0000_0000;
            rvalid <= 1'b0;
        end
        else
        begin
            rvalid <= req.rd;
            if (req.rd)
                rdata <= rd_nxt;
        end
    end

endmodule : tpc_timers

//--- rtl/tpc_pkg.sv
// Constants, register map and carrier types of the dual peripheral timer.
// Assumes one 100 MHz clock and a simple word-wide register port.
// Contract
// - Two-bit mode field: 01 pulse output, 10 width capture, 11 events.
// - Output polarity bit: 1 gives high width pulse, 0 low width pulse.
// - Output is driven whenever the mode field holds pulse output code.
// - On enable in pulse mode, refuse zero width or period not above width.
// - A refused start sets overflow and interrupt flags, counter unchanged.
// - Every timer register clears to zero on reset.
// - Internal clocking: period and width last twice their values.
// - Bit 31 of period and width is ignored.
// - Writes while running sit in buffers until the period ends.
// - Period-count bit 1 gives continuous waveform, 0 a single pulse.
// - Interrupt flag at period end if bit is 1, width end if 0.
// - Interrupt request only leaves when the interrupt enable bit is 1.
// - Write one to enable starts, to disable stops; one status read.
// - Counter held while disabled; re-enable reloads it by mode.
// - Capture mode: period and width read-only, loaded with captures.
// - Capture polarity bit picks pulse sense; period-count picks irq.
// - Capture mode sets the overflow flag and stops when the counter reaches all-ones.
// - Event mode counts rise on polarity 1, fall on 0; width unused.
// - Event mode sets the interrupt flag once the event period expires.
// - Pin buffer enable only in pulse mode; input sampled otherwise.
// - Capture mode restarts counter at one on each period capture.
// - Event mode flags interrupt when counter reaches all-ones minus one.
package tpc_pkg;

    localparam int NTMR = 2;
    localparam int AW = 8;

    // Register byte offsets
    localparam logic [7:0] OFS_STAT = 8'h00;
    localparam logic [7:0] OFS_TMR0 = 8'h10;
    localparam logic [7:0] OFS_TSTRIDE = 8'h10;
    localparam logic [3:0] OFS_CTL = 4'h0;
    localparam logic [3:0] OFS_CNT = 4'h4;
    localparam logic [3:0] OFS_PRD = 4'h8;
    localparam logic [3:0] OFS_WID = 4'hC;

    // Status bit positions, timer index added
    localparam int ST_IRQ = 0;
    localparam int ST_OVF = 4;
    localparam int ST_EN = 8;
    localparam int ST_DIS = 12;

    // Control bit positions
    localparam int CT_MODE = 0;
    localparam int CT_PULSE = 2;
    localparam int CT_PERCONT = 3;
    localparam int CT_IRQON = 4;

    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [31:0] CNT_ONE = 32'h0000_0001;
    localparam logic [31:0] CNT_ALL1 = 32'hFFFF_FFFF;
    localparam logic [31:0] CNT_ALL1_M1 = 32'hFFFF_FFFE;

    typedef enum logic [1:0] {
        TPC_MODE_OFF = 2'b00,
        TPC_MODE_PWM = 2'b01,
        TPC_MODE_CAP = 2'b10,
        TPC_MODE_EXT = 2'b11
    } tpc_mode_t;

    typedef struct packed {
        logic irq_on;
        logic per_cont;
        logic pulse;
        tpc_mode_t mode;
    } tpc_ctl_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [AW-1:0] addr;
        logic [31:0] wdata;
    } tpc_req_t;

endpackage : tpc_pkg

//--- tb/tpc_timers_monitor.sv
// Port checker for the dual timer; shadows timer 0 control and buffers.
// Assumes it is bound to tpc_timers and writes follow the port contract.
`timescale 1ns/1ns
module tpc_timers_monitor (
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Register port
    input wire tpc_pkg::tpc_req_t req,
    input wire logic [31:0] rdata,
    input wire logic rvalid,
    // Pins and interrupts
    input wire logic [tpc_pkg::NTMR-1:0] tmr_in,
    input wire logic [tpc_pkg::NTMR-1:0] tmr_out,
    input wire logic [tpc_pkg::NTMR-1:0] pben_n,
    input wire logic [tpc_pkg::NTMR-1:0] irq_req
);
    tpc_pkg::tpc_ctl_t ctl_r;
    logic [30:0] prd_r;
    logic [30:0] wid_r;
    logic [1:0] age_r;
    logic wr_ctl;
    logic bad_go;

    assign wr_ctl = req.wr && req.addr == 8'h10;
    // Shadow buffers only hold while timer 0 stays outside capture and event modes
    assign bad_go = req.wr && req.addr == 8'h00 && req.wdata[8]
        && !req.wdata[12] && ctl_r.mode == tpc_pkg::TPC_MODE_PWM
        && (wid_r == 31'h0 || prd_r <= wid_r);

    always_ff @(posedge mclk)
    begin
        if (srst)
            ctl_r <= '0;
        else if (wr_ctl)
            ctl_r <= tpc_pkg::tpc_ctl_t'(req.wdata[4:0]);
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
            prd_r <= 31'h0;
        else if (req.wr && req.addr == 8'h18)
            prd_r <= req.wdata[30:0];
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
            wid_r <= 31'h0;
        else if (req.wr && req.addr == 8'h1C)
            wid_r <= req.wdata[30:0];
    end

    // Pin outputs are registered behind the mode; allow them to settle
    always_ff @(posedge mclk)
    begin
        if (srst || wr_ctl)
            age_r <= 2'h0;
        else if (age_r != 2'h3)
            age_r <= age_r + 2'h1;
    end

    default clocking @(posedge mclk);
    endclocking
    default disable iff (srst);

    a_read_answer: assert property (req.rd |=> rvalid)
        else $error("no answer after read");
    a_answer_cause: assert property (rvalid |-> $past(req.rd))
        else $error("answer without read");
    a_data_holds: assert property (!$past(req.rd) |-> $stable(rdata))
        else $error("read data moved without read");
    a_reset_levels: assert property (
        $fell(srst) |-> pben_n == 2'b11 && irq_req == 2'b00 && !rvalid)
        else $error("outputs not at reset level");
    a_irq_gated: assert property (irq_req[0] |-> ctl_r.irq_on)
        else $error("interrupt request while disabled");
    a_pben_mode: assert property (
        age_r == 2'h3 |-> pben_n[0] == (ctl_r.mode != tpc_pkg::TPC_MODE_PWM))
        else $error("buffer enable does not follow mode");
    a_out_idle: assert property (
        age_r == 2'h3 && ctl_r.mode != tpc_pkg::TPC_MODE_PWM
        |-> tmr_out[0] == !ctl_r.pulse)
        else $error("output not idle outside pulse mode");
    a_bad_start: assert property (
        bad_go && ctl_r.irq_on |-> ##[1:4] irq_req[0])
        else $error("refused start raised no interrupt");
    a_irq_sticky: assert property ($fell(irq_req[0]) |-> $past(req.wr))
        else $error("interrupt flag dropped by itself");

    c_refused: cover property (bad_go);
    c_irq_pwm: cover property (irq_req[1]);
    c_pwm_pin: cover property (!pben_n[1]);
endmodule : tpc_timers_monitor

bind tpc_timers tpc_timers_monitor i_mon (.mclk(mclk), .srst(srst),
    .req(req), .rdata(rdata), .rvalid(rvalid), .tmr_in(tmr_in),
    .tmr_out(tmr_out), .pben_n(pben_n), .irq_req(irq_req));

//--- tb/tpc_pin_model.sv
// Waveform source on the far side of timer 0's input pin.
// Assumes nothing of mclk: its edges fall at unrelated times.
`timescale 1ns/1ns
module tpc_pin_model #(
    parameter int HI_NS = 83,
    parameter int LO_NS = 117
) (
    // Control
    input wire logic en,
    // Pin and edge count
    output logic sig,
    output int n_rise
);
    // Low first, so every pulse handed over is whole
    initial
    begin
        sig = 1'b0;
        n_rise = 0;
        forever
        begin
            wait (en);
            #(LO_NS);
            sig = 1'b1;
            n_rise++;
            #(HI_NS);
            sig = 1'b0;
        end
    end
endmodule : tpc_pin_model

//--- tb/tb.sv
// Self-checking bench: registers, pulse output, capture, event count.
// Assumes the pin model feeds timer 0; timer 1 reads its own output.
`timescale 1ns/1ns
module tb;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    tpc_pkg::tpc_req_t req = '0;
    logic [31:0] rdata;
    logic rvalid;
    logic [1:0] tmr_in;
    logic [1:0] tmr_out;
    logic [1:0] pben_n;
    logic [1:0] irq_req;
    logic src_en = 1'b0;
    logic src_sig;
    int src_rise;
    int n_mismatch = 0;
    int compares = 0;
    int cyc = 0;
    int n;
    logic [31:0] v;
    logic [31:0] w;

    always #5 mclk = ~mclk;
    assign tmr_in = {tmr_out[1], src_sig};

    tpc_timers i_dut (.mclk(mclk), .srst(srst), .req(req), .rdata(rdata),
        .rvalid(rvalid), .tmr_in(tmr_in), .tmr_out(tmr_out),
        .pben_n(pben_n), .irq_req(irq_req));
    tpc_pin_model i_src (.en(src_en), .sig(src_sig), .n_rise(src_rise));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(negedge mclk);
        req = {1'b1, 1'b0, a, d};
        @(negedge mclk);
        req = '0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(negedge mclk);
        req = {1'b0, 1'b1, a, 32'h0};
        @(negedge mclk);
        req = '0;
        chk({31'h0, rvalid}, 32'h1);
        d = rdata;
    endtask : rd

    task automatic run_len(input logic lvl, output int k);
        k = 0;
        for (int i = 0; i < 300 && tmr_out[1] !== lvl; i++)
            @(negedge mclk);
        while (tmr_out[1] === lvl && k < 300)
        begin
            @(negedge mclk);
            k++;
        end
    endtask : run_len

    // Edge detection lags the pin by about three clocks
    task automatic wait_rise(input int k);
        for (int i = 0; i < 300 && src_rise < k; i++)
            @(negedge mclk);
        repeat (6) @(negedge mclk);
    endtask : wait_rise

    task automatic stop_test;
        $display("compares=%0d mismatches=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : stop_test

    task automatic t_reset;
        for (int a = 0; a < 48; a += 4)
        begin
            rd(8'(a), v);
            chk(v, 32'h0);
        end
        wr(8'h40, 32'hFFFF_FFFF);
        rd(8'h40, v);
        chk(v, 32'h0);
        chk({30'h0, pben_n}, 32'h3);
        $display("t_reset done");
    endtask : t_reset

    task automatic t_refuse;
        logic [31:0] p [4] = '{32'h5, 32'h3, 32'h4, 32'h8000_0003};
        logic [31:0] q [4] = '{32'h0, 32'h5, 32'h4, 32'h3};
        wr(8'h10, 32'h11);
        for (int i = 0; i < 4; i++)
        begin
            wr(8'h18, p[i]);
            wr(8'h1C, q[i]);
            rd(8'h14, w);
            wr(8'h00, 32'h100);
            repeat (4) @(negedge mclk);
            chk({30'h0, irq_req[0], pben_n[0]}, 32'h2);
            rd(8'h00, v);
            chk(v, 32'h11);
            rd(8'h14, v);
            chk(v, w);
            wr(8'h00, 32'h11);
            rd(8'h00, v);
            chk(v, 32'h0);
        end
        $display("t_refuse done");
    endtask : t_refuse

    task automatic t_pwm;
        wr(8'h20, 32'hD);
        repeat (3) @(negedge mclk);
        chk({30'h0, tmr_out[1], pben_n[1]}, 32'h0);
        wr(8'h28, 32'h5);
        wr(8'h2C, 32'h2);
        wr(8'h00, 32'h200);
        run_len(1'b1, n);
        run_len(1'b1, n);
        chk(n, 32'h4);
        run_len(1'b0, n);
        chk(n, 32'h6);
        run_len(1'b1, n);
        wr(8'h28, 32'h7);
        wr(8'h2C, 32'h3);
        run_len(1'b0, n);
        chk(n, 32'h2);
        run_len(1'b1, n);
        chk(n, 32'h6);
        run_len(1'b0, n);
        chk(n, 32'h8);
        rd(8'h00, v);
        chk(v & 32'h202, 32'h202);
        chk({31'h0, irq_req[1]}, 32'h0);
        wr(8'h20, 32'h1D);
        chk({31'h0, irq_req[1]}, 32'h1);
        wr(8'h00, 32'h2000);
        repeat (3) @(negedge mclk);
        rd(8'h00, v);
        chk(v & 32'h200, 32'h0);
        chk({31'h0, tmr_out[1]}, 32'h0);
        rd(8'h24, w);
        repeat (5) @(negedge mclk);
        rd(8'h24, v);
        chk(v, w);
        wr(8'h00, 32'h2);
        $display("t_pwm done");
    endtask : t_pwm

    task automatic t_single;
        wr(8'h20, 32'h11);
        wr(8'h28, 32'h6);
        wr(8'h2C, 32'h3);
        wr(8'h00, 32'h200);
        run_len(1'b0, n);
        chk({31'h0, n >= 5 && n <= 7}, 32'h1);
        n = 0;
        repeat (40)
        begin
            @(negedge mclk);
            n += (tmr_out[1] !== 1'b1);
        end
        chk(n, 32'h0);
        chk({31'h0, irq_req[1]}, 32'h1);
        rd(8'h00, v);
        chk(v & 32'h202, 32'h2);
        wr(8'h00, 32'h2);
        $display("t_single done");
    endtask : t_single

    task automatic t_capture;
        wr(8'h10, 32'h1E);
        wr(8'h00, 32'h100);
        src_en = 1'b1;
        wait_rise(src_rise + 4);
        chk({30'h0, irq_req[0], pben_n[0]}, 32'h3);
        wr(8'h18, 32'h55);
        rd(8'h18, v);
        chk({31'h0, v >= 32'hA && v <= 32'hC}, 32'h1);
        rd(8'h1C, v);
        chk({31'h0, v >= 32'h4 && v <= 32'h6}, 32'h1);
        wr(8'h00, 32'h1000);
        src_en = 1'b0;
        // Let a pulse under way finish so no stray edge reaches the next test
        repeat (25) @(negedge mclk);
        wr(8'h00, 32'h11);
        $display("t_capture done");
    endtask : t_capture

    task automatic t_event;
        int r0;
        wr(8'h10, 32'h17);
        rd(8'h1C, w);
        wr(8'h1C, 32'h99);
        rd(8'h1C, v);
        chk(v, w);
        wr(8'h18, 32'h3);
        wr(8'h00, 32'h100);
        r0 = src_rise;
        src_en = 1'b1;
        wait_rise(r0 + 2);
        chk({31'h0, irq_req[0]}, 32'h0);
        wait_rise(r0 + 3);
        chk({31'h0, irq_req[0]}, 32'h1);
        wr(8'h00, 32'h1000);
        src_en = 1'b0;
        $display("t_event done");
    endtask : t_event

    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            stop_test();
        end
    end

    initial
    begin
        repeat (16) @(negedge mclk);
        srst = 1'b0;
        t_reset();
        t_refuse();
        t_pwm();
        t_single();
        t_capture();
        t_event();
        stop_test();
    end
endmodule : tb
